// [verilog/wcl_top.sv]
`timescale 1ns/1ps
`include "wcl_map.svh"
// Function
// [R01] wrap valid: span/range and range*steps integer
// [R02] offset ratio shifts wrap range negative
// [R03] signed step offset fine-adjusts home further
// [R04] wrap enable/range change requires re-homing
// [R05] new wrap settings active after power cycle
// [R06] invalid wrap setting raises error information
// [R07] positive and negative limits with stop method
// [R08] stop method: decelerate with brake, or immediate
// [R09] preset stores command position plus/minus one
// [R10] limit writes counted against memory endurance
// [R11] homing completion sets command position zero
// [R12] reaching software limit raises overtravel alarm
// [R13] fast homing without valid home: start error
// [R14] controller asserts homing request to start homing
// [R15] wrap enable 0 off, 1 on, reset on
// [R16] apply with error information escalates to alarm
// [R17] wrapping presets position to opposite range end
module wcl_top
  import wcl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        step_pulse,
  input  wire logic        step_dir,
  input  wire logic        homing_done,
  input  wire logic        hs_start,
  input  wire logic        home_valid,
  input  wire logic [15:0] brake_decel,
  input  wire logic        homing_request,
  output wcl_pos_t         command_position,
  output logic             stop_decel,
  output logic             stop_immed,
  output logic      [15:0] stop_rate,
  output logic             ot_alarm,
  output logic             wrap_info,
  output logic             wrap_alarm,
  output logic             rehome_needed,
  output logic             homing_go,
  output logic             high_speed_homing_go,
  output logic             irq
);
  // ==========================================================
  // apb decode
  wire access = psel & penable & pready;
  wire wr     = access & pwrite;
  wire rd     = access & ~pwrite;
  wire in_map = (paddr[1:0] == 2'b00) && (paddr <= `WCL_A_UPPER);
  wire wr_ctrl   = wr && paddr == `WCL_A_CTRL;
  wire wr_range  = wr && paddr == `WCL_A_RANGE;
  wire wr_ratio  = wr && paddr == `WCL_A_RATIO;
  wire wr_offset = wr && paddr == `WCL_A_OFFSET;
  wire wr_steps  = wr && paddr == `WCL_A_STEPS;
  wire apply     = wr && paddr == `WCL_A_APPLY;
  wire wr_poslim = wr && paddr == `WCL_A_POSLIM;
  wire wr_neglim = wr && paddr == `WCL_A_NEGLIM;
  wire wr_cmd    = wr && paddr == `WCL_A_CMD;
  wire wr_mask   = wr && paddr == `WCL_A_MASK;
  wire rd_status = rd && paddr == `WCL_A_STATUS;

  // ==========================================================
  // pending and active configuration
  logic        pend_wrap, pend_immed, pend_small;
  logic [15:0] pend_range, pend_ratio, pend_steps;
  wcl_pos_t    pend_offset;
  logic        act_wrap, act_small;
  logic [15:0] act_range, act_ratio, act_steps;
  wcl_pos_t    act_offset;
  wcl_pos_t    pos_limit, neg_limit;
  wcl_stat_t   status, mask;
  logic [31:0] nv_count;
  logic        at_lim_q, req_q;
  wcl_pos_t    act_lower, act_upper, pend_lower, pend_upper;
  logic        act_valid, pend_valid, req_sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_wrap   <= `WCL_RST_WRAP; // see [R15]
      pend_immed  <= 1'b0;
      pend_small  <= 1'b0;
      pend_range  <= `WCL_RST_RANGE;
      pend_ratio  <= `WCL_RST_RATIO;
      pend_steps  <= `WCL_RST_STEPS;
      pend_offset <= 32'sh00000000;
    end
    else
    begin
      if (wr_ctrl)
      begin
        pend_wrap  <= pwdata[`WCL_CTRL_WRAP];
        pend_immed <= pwdata[`WCL_CTRL_IMMED];
        pend_small <= pwdata[`WCL_CTRL_SMALL];
      end
      if (wr_range)
        pend_range <= pwdata[15:0];
      if (wr_ratio)
        pend_ratio <= pwdata[15:0];
      if (wr_steps)
        pend_steps <= pwdata[15:0];
      if (wr_offset)
        pend_offset <= {{2{pwdata[29]}}, pwdata[29:0]};
    end
  end

  // apply stands for a power cycle or configuration run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_wrap   <= `WCL_RST_WRAP;
      act_small  <= 1'b0;
      act_range  <= `WCL_RST_RANGE;
      act_ratio  <= `WCL_RST_RATIO;
      act_steps  <= `WCL_RST_STEPS;
      act_offset <= 32'sh00000000;
    end
    else if (apply) // see [R05]
    begin
      act_wrap   <= pend_wrap;
      act_small  <= pend_small;
      act_range  <= pend_range;
      act_ratio  <= pend_ratio;
      act_steps  <= pend_steps;
      act_offset <= pend_offset;
    end
  end

  wcl_wrap_calc u_act_calc (
    .range_tenths (act_range),
    .steps_rev    (act_steps),
    .span_small   (act_small),
    .ratio        (act_ratio),
    .offset       (act_offset),
    .valid        (act_valid),
    .lower        (act_lower),
    .upper        (act_upper)
  );

  wcl_wrap_calc u_pend_calc (
    .range_tenths (pend_range),
    .steps_rev    (pend_steps),
    .span_small   (pend_small),
    .ratio        (pend_ratio),
    .offset       (pend_offset),
    .valid        (pend_valid),
    .lower        (pend_lower),
    .upper        (pend_upper)
  );

  wcl_sync #(.W(1)) u_req_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (homing_request),
    .dout    (req_sync)
  );

  // ==========================================================
  // events and next values
  wire next_info = pend_wrap & ~pend_valid; // see [R06]
  wire wrap_on   = act_wrap & act_valid & ~wrap_alarm;
  wire cfg_moved = (pend_wrap != act_wrap) || (pend_range != act_range);
  wire home_ok   = home_valid & ~rehome_needed;
  wire hs_err    = hs_start & ~home_ok; // see [R13]
  wire at_lim    = (command_position >= pos_limit) ||
                   (command_position <= neg_limit);
  wire ot_event  = at_lim & ~at_lim_q; // see [R07] see [R12]
  wire preset_p  = wr_cmd & pwdata[`WCL_CMD_PPOS];
  wire preset_n  = wr_cmd & pwdata[`WCL_CMD_PNEG];
  wire lim_write = wr_poslim | wr_neglim | preset_p | preset_n;
  wire nv_wear   = nv_count >= `WCL_NV_LIMIT;
  wire walm_set  = apply & wrap_info; // see [R16]
  wire at_upper  = command_position >= act_upper;
  wire at_lower  = command_position <= act_lower;
  wire [`WCL_NSTAT-1:0] events = {lim_write & nv_wear, homing_done,
                                  hs_err, ot_event,
                                  walm_set & ~wrap_alarm,
                                  next_info & ~wrap_info};
  wire [`WCL_NSTAT-1:0] clr_mask = rd_status ? 6'h3f : 6'h00;
  wire [`WCL_NSTAT-1:0] next_status = (status & ~clr_mask) | events;
  wcl_pos_t next_command_position;
  assign next_command_position =
    homing_done ? 32'sh00000000 : // see [R11]
    !step_pulse ? command_position :
    step_dir ? ((wrap_on && at_upper) ? act_lower // see [R17]
                                      : command_position + 32'sh00000001)
             : ((wrap_on && at_lower) ? act_upper
                                      : command_position - 32'sh00000001);
  wire [31:0] rd_mux =
    (paddr == `WCL_A_CTRL)   ? {29'h0, pend_small, pend_immed, pend_wrap} :
    (paddr == `WCL_A_RANGE)  ? {16'h0000, pend_range} :
    (paddr == `WCL_A_RATIO)  ? {16'h0000, pend_ratio} :
    (paddr == `WCL_A_OFFSET) ? pend_offset :
    (paddr == `WCL_A_STEPS)  ? {16'h0000, pend_steps} :
    (paddr == `WCL_A_POSLIM) ? pos_limit :
    (paddr == `WCL_A_NEGLIM) ? neg_limit :
    (paddr == `WCL_A_COMMAND_POSITION)   ? command_position :
    (paddr == `WCL_A_STATUS) ? {26'h0, status} :
    (paddr == `WCL_A_MASK)   ? {26'h0, mask} :
    (paddr == `WCL_A_STATE)  ? {26'h0, act_valid, act_wrap, rehome_needed,
                                ot_alarm, wrap_alarm, wrap_info} :
    (paddr == `WCL_A_NVCNT)  ? nv_count :
    (paddr == `WCL_A_LOWER)  ? act_lower :
    (paddr == `WCL_A_UPPER)  ? act_upper : 32'h00000000;

  // ==========================================================
  // bus answer: one wait state, registered read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~in_map;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux
                                                      : 32'h00000000;
    end
  end

  // ==========================================================
  // position, limits and alarms
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      command_position <= 32'sh00000000;
    else
      command_position <= next_command_position;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_limit <= `WCL_RST_POSLIM;
      neg_limit <= `WCL_RST_NEGLIM;
      nv_count  <= 32'h00000000;
    end
    else
    begin
      if (preset_p)
        pos_limit <= command_position + 32'sh00000001; // see [R09]
      else if (wr_poslim)
        pos_limit <= pwdata;
      if (preset_n)
        neg_limit <= command_position - 32'sh00000001; // see [R09]
      else if (wr_neglim)
        neg_limit <= pwdata;
      if (lim_write && nv_count != 32'hffffffff)
        nv_count <= nv_count + 32'h00000001; // see [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      at_lim_q   <= 1'b0;
      ot_alarm   <= 1'b0;
      stop_decel <= 1'b0;
      stop_immed <= 1'b0;
      stop_rate  <= 16'h0000;
    end
    else
    begin
      at_lim_q   <= at_lim;
      ot_alarm   <= ot_event | (ot_alarm & ~(wr_cmd & pwdata[`WCL_CMD_ARST]));
      stop_decel <= ot_event & (pend_immed == WCL_STOP_DECEL); // see [R08]
      stop_immed <= ot_event & (pend_immed == WCL_STOP_IMMED); // see [R08]
      if (ot_event)
        stop_rate <= brake_decel;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wrap_info     <= 1'b0;
      wrap_alarm    <= 1'b0;
      rehome_needed <= 1'b0;
    end
    else
    begin
      wrap_info  <= next_info;
      wrap_alarm <= walm_set | (wrap_alarm & ~(apply & pend_valid));
      if (apply && cfg_moved)
        rehome_needed <= 1'b1; // see [R04]
      else if (homing_done)
        rehome_needed <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q                <= 1'b0;
      homing_go            <= 1'b0;
      high_speed_homing_go <= 1'b0;
      status               <= 6'h00;
      mask                 <= 6'h00;
      irq                  <= 1'b0;
    end
    else
    begin
      req_q                <= req_sync;
      homing_go            <= req_sync & ~req_q; // see [R14]
      high_speed_homing_go <= hs_start & home_ok;
      status               <= next_status;
      if (wr_mask)
        mask <= pwdata[`WCL_NSTAT-1:0];
      irq <= |(next_status & (wr_mask ? pwdata[`WCL_NSTAT-1:0] : mask));
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_info_raise: assert property ( // see [R06]
    pend_wrap && !pend_valid |=> wrap_info)
    else $error("wrap error information not raised");
  a_active_hold: assert property ( // see [R05]
    !apply |=> $stable(act_range) && $stable(act_wrap))
    else $error("active wrap settings changed without apply");
  a_alarm_escal: assert property ( // see [R16]
    apply && wrap_info |=> wrap_alarm)
    else $error("wrap error not escalated on apply");
  a_preset_plus: assert property ( // see [R09]
    preset_p |=> pos_limit == $past(command_position) + 32'sh00000001)
    else $error("positive preset value wrong");
  a_preset_minus: assert property ( // see [R09]
    preset_n |=> neg_limit == $past(command_position) - 32'sh00000001)
    else $error("negative preset value wrong");
  a_home_zero: assert property ( // see [R11]
    homing_done |=> command_position == 32'sh00000000)
    else $error("position not zero after homing");
  a_ot_alarm: assert property ( // see [R12]
    ot_event |=> ot_alarm ##0 (stop_decel ^ stop_immed))
    else $error("overtravel alarm or stop missing");
  a_hs_error: assert property ( // see [R13]
    hs_start && !home_ok |=> status[`WCL_ST_HSERR] && !high_speed_homing_go)
    else $error("fast homing start error missing");
  a_wrap_up: assert property ( // see [R17]
    wrap_on && step_pulse && step_dir && at_upper && !homing_done
    |=> command_position == $past(act_lower))
    else $error("upward wrap did not land on lower end");
  a_rehome_flag: assert property ( // see [R04]
    apply && cfg_moved |=> rehome_needed)
    else $error("re-homing demand not raised");
  a_status_sticky: assert property (
    status[`WCL_ST_OT] && !rd_status |=> status[`WCL_ST_OT])
    else $error("sticky status lost");

  c_wrap: cover property (wrap_on && step_pulse && at_upper);
  c_ot: cover property (ot_event ##[1:20] wr_cmd);
  c_home: cover property (hs_start && home_ok ##[1:50] homing_done);
  c_escal: cover property (walm_set);
endmodule // wcl_top

// [common/wcl_map.svh]
`ifndef WCL_MAP_SVH
`define WCL_MAP_SVH
// ==========================================================
// register offsets (byte addresses)
`define WCL_A_CTRL     8'h00
`define WCL_A_RANGE    8'h04
`define WCL_A_RATIO    8'h08
`define WCL_A_OFFSET   8'h0c
`define WCL_A_STEPS    8'h10
`define WCL_A_APPLY    8'h14
`define WCL_A_POSLIM   8'h18
`define WCL_A_NEGLIM   8'h1c
`define WCL_A_CMD      8'h20
`define WCL_A_COMMAND_POSITION     8'h24
`define WCL_A_STATUS   8'h28
`define WCL_A_MASK     8'h2c
`define WCL_A_STATE    8'h30
`define WCL_A_NVCNT    8'h34
`define WCL_A_LOWER    8'h38
`define WCL_A_UPPER    8'h3c
// ==========================================================
// field positions
`define WCL_CTRL_WRAP  0
`define WCL_CTRL_IMMED 1
`define WCL_CTRL_SMALL 2
`define WCL_CMD_PPOS   0
`define WCL_CMD_PNEG   1
`define WCL_CMD_ARST   2
`define WCL_ST_INFO    0
`define WCL_ST_WALM    1
`define WCL_ST_OT      2
`define WCL_ST_HSERR   3
`define WCL_ST_HOMED   4
`define WCL_ST_NVWEAR  5
`define WCL_NSTAT      6
// ==========================================================
// reset values and scale factors
`define WCL_RST_WRAP   1'b1
`define WCL_RST_RANGE  16'h000a
`define WCL_RST_RATIO  16'h1388
`define WCL_RST_STEPS  16'h03e8
`define WCL_RST_POSLIM 32'h7fffffff
`define WCL_RST_NEGLIM 32'h80000000
`define WCL_SPAN_BIG   32'h00004650
`define WCL_SPAN_SMALL 32'h00002328
`define WCL_TENTHS     32'h0000000a
`define WCL_RATIO_FULL 48'h000000002710
`define WCL_NV_LIMIT   32'h000186a0
`endif

// [common/wcl_pkg.sv]
package wcl_pkg;
  typedef logic signed [31:0] wcl_pos_t;
  typedef enum logic {
    WCL_STOP_DECEL = 1'b0,
    WCL_STOP_IMMED = 1'b1
  } wcl_stop_t;
  typedef logic [5:0] wcl_stat_t;
endpackage

// [verilog/wcl_sync.sv]
`timescale 1ns/1ps
module wcl_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // wcl_sync

// [verilog/wcl_wrap_calc.sv]
`timescale 1ns/1ps
`include "wcl_map.svh"
module wcl_wrap_calc
  import wcl_pkg::*;
(
  input  wire logic [15:0] range_tenths,
  input  wire logic [15:0] steps_rev,
  input  wire logic        span_small,
  input  wire logic [15:0] ratio,
  input  wire wcl_pos_t    offset,
  output logic             valid,
  output wcl_pos_t         lower,
  output wcl_pos_t         upper
);
  // ==========================================================
  // integer checks on span / range and range * resolution
  wire [31:0] span_t  = span_small ? `WCL_SPAN_SMALL : `WCL_SPAN_BIG;
  wire [31:0] range32 = {16'h0000, range_tenths};
  wire [31:0] prod    = range32 * {16'h0000, steps_rev};
  wire        cond1   = (range32 != 32'h0) && ((span_t % range32) == 32'h0);
  wire        cond2   = (prod % `WCL_TENTHS) == 32'h0;
  assign valid = cond1 && cond2 && (steps_rev != 16'h0); // see [R01]
  // ==========================================================
  // range in steps, shifted negative by the ratio, then by offset
  wire [31:0] width = prod / `WCL_TENTHS;
  wire [47:0] shift_full = ({16'h0000, width} * {32'h0, ratio})
                           / `WCL_RATIO_FULL;
  wire signed [31:0] shift = $signed(shift_full[31:0]);
  assign lower = offset - shift; // see [R02] see [R03]
  assign upper = lower + $signed(width) - 32'sh00000001;
endmodule // wcl_wrap_calc

// [tb/wcl_motor_model.sv]
`timescale 1ns/1ps
module wcl_motor_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mv_go,
  input  wire logic [15:0] mv_n,
  input  wire logic        mv_dir,
  input  wire logic        slow,
  input  wire logic        home_go,
  output logic             step_pulse,
  output logic             step_dir,
  output logic             homing_done,
  output logic             busy
);
  logic [15:0] left;
  logic [1:0]  gap;
  logic        dir_q;
  logic [3:0]  hcnt;

  assign busy = (left != 16'h0000) || step_pulse;

  // ==========================================================
  // step train and homing answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left        <= 16'h0000;
      gap         <= 2'h0;
      dir_q       <= 1'b0;
      hcnt        <= 4'h0;
      step_pulse  <= 1'b0;
      step_dir    <= 1'b0;
      homing_done <= 1'b0;
    end
    else
    begin
      step_pulse  <= 1'b0;
      homing_done <= 1'b0;
      // idle direction line churns, never holds a stale level
      step_dir    <= ~step_dir;
      if (mv_go)
      begin
        left  <= mv_n;
        dir_q <= mv_dir;
      end
      else if (left != 16'h0000 && gap == 2'h0)
      begin
        step_pulse <= 1'b1;
        step_dir   <= dir_q;
        left       <= left - 16'h0001;
        gap        <= slow ? 2'h2 : 2'h0;
      end
      else if (gap != 2'h0)
        gap <= gap - 2'h1;
      if (home_go)
        hcnt <= 4'h8;
      else if (hcnt != 4'h0)
      begin
        hcnt        <= hcnt - 4'h1;
        homing_done <= (hcnt == 4'h1) && (left == 16'h0000);
      end
    end
  end
endmodule // wcl_motor_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "wcl_map.svh"
module testbench
  import wcl_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, step_pulse, step_dir;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv, lo, up;
  logic        hs_start = 1'b0, home_valid = 1'b0, homing_request = 1'b0;
  logic [15:0] brake_decel = 16'h0, stop_rate, mv_n = 16'h0;
  logic        mv_go = 1'b0, mv_dir = 1'b0, slow = 1'b0, busy, any_home;
  logic        stop_decel, stop_immed, ot_alarm, wrap_info, wrap_alarm;
  logic        rehome_needed, homing_go, high_speed_homing_go, irq, err;
  logic        homing_done, v, pv;
  wcl_pos_t    command_position;
  int          error_cnt = 0, n_compared = 0, n_dec = 0, n_imm = 0;
  int          n_hgo = 0, n_hs = 0, r, s, q, o;
  logic [7:0]  ra [10] = '{`WCL_A_CTRL, `WCL_A_RANGE, `WCL_A_RATIO,
    `WCL_A_OFFSET, `WCL_A_STEPS, `WCL_A_POSLIM, `WCL_A_NEGLIM,
    `WCL_A_MASK, `WCL_A_LOWER, `WCL_A_UPPER};
  logic [31:0] re [10] = '{32'h1, 32'ha, 32'h1388, 32'h0, 32'h3e8,
    32'h7fffffff, 32'h80000000, 32'h0, 32'hfffffe0c, 32'h1f3};

  always #10 pclk = ~pclk;
  assign any_home = homing_go | high_speed_homing_go;

  wcl_top wcl_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pulse(step_pulse), .step_dir(step_dir),
    .homing_done(homing_done), .hs_start(hs_start),
    .home_valid(home_valid), .brake_decel(brake_decel),
    .homing_request(homing_request), .command_position(command_position),
    .stop_decel(stop_decel), .stop_immed(stop_immed),
    .stop_rate(stop_rate), .ot_alarm(ot_alarm), .wrap_info(wrap_info),
    .wrap_alarm(wrap_alarm), .rehome_needed(rehome_needed),
    .homing_go(homing_go), .high_speed_homing_go(high_speed_homing_go),
    .irq(irq));

  wcl_motor_model wcl_motor_model_inst (.pclk(pclk), .presetn(presetn),
    .mv_go(mv_go), .mv_n(mv_n), .mv_dir(mv_dir), .slow(slow),
    .home_go(any_home), .step_pulse(step_pulse), .step_dir(step_dir),
    .homing_done(homing_done), .busy(busy));

  // ==========================================================
  // pulse counters
  always @(posedge pclk)
  begin
    n_dec += (stop_decel === 1'b1);
    n_imm += (stop_immed === 1'b1);
    n_hgo += (homing_go === 1'b1);
    n_hs  += (high_speed_homing_go === 1'b1);
  end

  // ==========================================================
  // expectation functions
  function automatic logic val_f(int r, int s);
    return r != 0 && 18000 % r == 0 && (r * s) % 10 == 0;
  endfunction

  function automatic logic [31:0] lo_f(int r, int s, int q, int o);
    longint w;
    w = r * s / 10;
    return 32'(o - w * q / 10000);
  endfunction

  // ==========================================================
  // bus, motion and compare tasks
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 16)
    begin
      @(posedge pclk);
      k++;
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16)
    begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rdv, exp);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic mv(int n, logic d);
    int k;
    @(posedge pclk);
    mv_go <= 1'b1;
    mv_n <= 16'(n);
    mv_dir <= d;
    slow <= 1'($urandom);
    @(posedge pclk);
    mv_go <= 1'b0;
    k = 0;
    @(posedge pclk);
    while (busy === 1'b1 && k < 4000)
    begin
      @(posedge pclk);
      k++;
    end
    idle(2);
    if (k >= 4000)
    begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic hs();
    @(posedge pclk);
    hs_start <= 1'b1;
    @(posedge pclk);
    hs_start <= 1'b0;
    idle(3);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h369d8233));
    brake_decel <= 16'($urandom);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd(ra[i], re[i]);
    apb(1'b0, 8'h42, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rdv, 32'h0);
    $display("test reset done");

    mv(5, 1'b1);
    chk("command_position", command_position, 32'h5);
    wr(`WCL_A_CMD, 32'h1);
    rd(`WCL_A_POSLIM, 32'h6);
    mv(1, 1'b1);
    chk("ot", 32'(ot_alarm), 32'h1);
    chk("decel", n_dec, 32'h1);
    chk("rate", 32'(stop_rate), 32'(brake_decel));
    chk("irq masked", 32'(irq), 32'h0);
    wr(`WCL_A_MASK, 32'h4);
    idle(2);
    chk("irq", 32'(irq), 32'h1);
    rd(`WCL_A_STATUS, 32'h4);
    idle(2);
    chk("irq clear", 32'(irq), 32'h0);
    wr(`WCL_A_CMD, 32'h4);
    wr(`WCL_A_CTRL, 32'h3);
    mv(1, 1'b0);
    chk("ot reset", 32'(ot_alarm), 32'h0);
    wr(`WCL_A_CMD, 32'h2);
    rd(`WCL_A_NEGLIM, 32'h4);
    mv(1, 1'b0);
    chk("immed", n_imm, 32'h1);
    chk("decel once", n_dec, 32'h1);
    chk("ot neg", 32'(ot_alarm), 32'h1);
    wr(`WCL_A_CMD, 32'h4);
    rd(`WCL_A_NVCNT, 32'h2);
    wr(`WCL_A_POSLIM, 32'h7fffffff);
    wr(`WCL_A_NEGLIM, 32'h80000000);
    wr(`WCL_A_CTRL, 32'h1);
    apb(1'b0, `WCL_A_STATUS, 32'h0);
    $display("test limits done");

    mv(495, 1'b1);
    chk("command_position top", command_position, 32'd499);
    mv(1, 1'b1);
    chk("wrap up", command_position, 32'hfffffe0c);
    mv(1, 1'b0);
    chk("wrap down", command_position, 32'd499);
    $display("test wrap done");

    pv = 1'b1;
    lo = 32'hfffffe0c;
    for (int i = 0; i < 6; i++)
    begin
      r = (i == 0) ? 70 : (i == 1 || i == 5) ? 10 * (i + 17) / (i + 1) :
        $urandom_range(1, 400);
      s = (i < 2 || i == 5) ? 1000 : $urandom_range(100, 2000);
      q = $urandom_range(0, 10000);
      o = $urandom_range(0, 2000) - 1000;
      v = val_f(r, s);
      wr(`WCL_A_RANGE, 32'(r));
      wr(`WCL_A_STEPS, 32'(s));
      wr(`WCL_A_RATIO, 32'(q));
      wr(`WCL_A_OFFSET, 32'(o));
      idle(2);
      chk("info", 32'(wrap_info), 32'(!v));
      if (pv)
        rd(`WCL_A_LOWER, lo);
      wr(`WCL_A_APPLY, 32'h1);
      idle(2);
      chk("alarm", 32'(wrap_alarm), 32'(!v));
      rd(`WCL_A_STATE, {26'h0, v, 2'b11, 1'b0, !v, !v});
      lo = lo_f(r, s, q, o);
      up = lo + 32'(r * s / 10) - 32'h1;
      if (v)
        rd(`WCL_A_LOWER, lo);
      if (v)
        rd(`WCL_A_UPPER, up);
      pv = v;
    end
    chk("rehome", 32'(rehome_needed), 32'h1);
    $display("test config done");

    home_valid <= 1'b1;
    hs();
    chk("hs refused", n_hs, 32'h0);
    apb(1'b0, `WCL_A_STATUS, 32'h0);
    chk("hs err rehome", 32'(rdv[3]), 32'h1);
    homing_request <= 1'b1;
    idle(5);
    chk("home go", n_hgo, 32'h1);
    idle(12);
    chk("home pos", command_position, 32'h0);
    chk("rehome clr", 32'(rehome_needed), 32'h0);
    homing_request <= 1'b0;
    home_valid <= 1'b0;
    hs();
    chk("hs invalid", n_hs, 32'h0);
    apb(1'b0, `WCL_A_STATUS, 32'h0);
    chk("hs err", 32'(rdv[3]), 32'h1);
    home_valid <= 1'b1;
    hs();
    chk("hs go", n_hs, 32'h1);
    idle(12);
    $display("test homing done");
    end_sim();
  end
endmodule // testbench
